// ===== bdu_breakpoint_unit.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - four address registers; a matching access of configured type on an enabled slot raises debug exception
// - access type 00 execute, 01 data write, 10 unused, 11 data read or write
// - size 00 one byte, 01 two bytes, 10 one byte, 11 four bytes
// - execute breakpoints are taken before the matching instruction runs
// - on an exception every matching breakpoint sets its hit flag, enabled or not
// - exception from single stepping sets the single-step status bit
// - status is cleared only by sys_rst or by software; exceptions never clear it
// - global enables arm for all tasks and survive task switches
// - local enables arm for current task and clear on every task switch
// - debug registers reachable only by register moves at privilege level 0
// - with trap flag set, a debug exception follows every completed instruction
// - software breakpoint instruction enters the breakpoint exception path
module bdu_breakpoint_unit (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // register-move port from the core
  input  wire bdu_pkg::bdu_regcmd_t reg_cmd,
  output logic [31:0]               reg_rdata_q,
  output logic                      reg_fault_q,
  // fetch and data access pipeline
  input  wire bdu_pkg::bdu_access_t exec_acc,
  input  wire bdu_pkg::bdu_access_t data_acc,
  input  wire logic                 instr_done,
  input  wire logic                 trap_step_flag,
  input  wire logic                 task_switch,
  input  wire logic                 task_switch_trap_flag,
  input  wire logic                 sw_bkpt_exec,
  // exceptions to the core
  output logic                      dbg_exc_q,
  output logic                      bkpt_exc_q
);

  // ************************************************************
  // address match helper
  // ************************************************************
  // overlap of the access byte range with the aligned span; 33 bits so a
  // span at the top of memory does not wrap into a missed hit
  function automatic logic bp_hit(input logic [31:0] bp, input logic [1:0] len,
                                  input logic [31:0] a, input logic [1:0] sz);
    logic [32:0] lo_b;
    logic [32:0] hi_b;
    logic [32:0] hi_a;
    logic [1:0]  span;
    span = (len == bdu_pkg::LEN_4) ? 2'h3 : {1'b0, len[0]};
    lo_b = {1'b0, bp[31:2], bp[1:0] & ~span};
    hi_b = lo_b + {31'h0, span};
    hi_a = {1'b0, a} + {31'h0, sz};
    bp_hit = ({1'b0, a} <= hi_b) && (lo_b <= hi_a);
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] addr_q [bdu_pkg::NUM_BP];
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] control_q;
  logic [31:0] control_d;

  // ************************************************************
  // matching
  // ************************************************************
  logic [3:0] exec_m;
  logic [3:0] data_m;
  logic [3:0] armed;

  for (genvar i = 0; i < bdu_pkg::NUM_BP; i++)
  begin : g_bp
    wire logic [1:0] rw  = control_q[bdu_pkg::CT_FIELD_LSB + bdu_pkg::CT_GRP_W*i +: 2];
    wire logic [1:0] len = control_q[bdu_pkg::CT_FIELD_LSB + bdu_pkg::CT_GRP_W*i + 2 +: 2];
    // type 10 matches nothing
    assign exec_m[i] = exec_acc.valid && rw == bdu_pkg::RW_EXEC
                       && bp_hit(addr_q[i], len, exec_acc.addr, 2'h0);
    assign data_m[i] = data_acc.valid && (rw == bdu_pkg::RW_RDWR
                       || (rw == bdu_pkg::RW_WRITE && data_acc.we))
                       && bp_hit(addr_q[i], len, data_acc.addr, data_acc.size);
    assign armed[i]  = control_q[2*i] | control_q[2*i+1];
  end

  // ************************************************************
  // exception causes and register access
  // ************************************************************
  wire logic [3:0] hit_any  = exec_m | data_m;
  wire logic       reg_req  = reg_cmd.rd | reg_cmd.wr;
  wire logic       priv_ok  = reg_cmd.cpl == bdu_pkg::PL_ZERO;
  wire logic       grd_set  = control_q[bdu_pkg::CT_GUARD_BIT];
  wire logic       grd_trip = reg_req && priv_ok && grd_set;
  wire logic       acc_ok   = priv_ok && !grd_set;
  wire logic       wr_ok    = reg_cmd.wr && acc_ok;
  wire logic       step_hit = instr_done && trap_step_flag;
  wire logic       ts_hit   = task_switch && task_switch_trap_flag;
  wire logic       bp_trig  = |(hit_any & armed);
  wire logic       exc      = bp_trig | grd_trip | step_hit | ts_hit;
  wire logic       wr_st    = wr_ok && reg_cmd.idx == bdu_pkg::IDX_STATUS;
  wire logic       wr_ct    = wr_ok && reg_cmd.idx == bdu_pkg::IDX_CONTROL;

  // status: software write first, hardware sets on top so an event wins
  always_comb
  begin
    status_d = wr_st ? (reg_cmd.wdata & bdu_pkg::ST_WMASK) : status_q;
    if (exc)
    begin
      status_d[3:0] = status_d[3:0] | hit_any;
      status_d[bdu_pkg::ST_TSW_BIT] = status_d[bdu_pkg::ST_TSW_BIT] | ts_hit;
      status_d[bdu_pkg::ST_STEP_BIT] = status_d[bdu_pkg::ST_STEP_BIT] | step_hit;
    end
  end

  // control: task switch drops locals only, exception drops the guard
  always_comb
  begin
    control_d = wr_ct ? (reg_cmd.wdata & bdu_pkg::CT_WMASK) : control_q;
    if (task_switch)
      control_d = control_d & ~bdu_pkg::CT_LOCALS;
    if (exc)
      control_d[bdu_pkg::CT_GUARD_BIT] = 1'b0;
  end

  wire logic [31:0] rd_sel =
    (reg_cmd.idx == bdu_pkg::IDX_STATUS)  ? status_q  :
    (reg_cmd.idx == bdu_pkg::IDX_CONTROL) ? control_q :
    (reg_cmd.idx[2] == 1'b0)              ? addr_q[reg_cmd.idx[1:0]] : bdu_pkg::RST_VAL;

  // ************************************************************
  // registers
  // ************************************************************
  // address registers only change under a permitted write or sys_rst
  always_ff @(posedge clk)
    if (sys_rst)
      for (int k = 0; k < bdu_pkg::NUM_BP; k++)
        addr_q[k] <= bdu_pkg::RST_VAL;
    else if (wr_ok && reg_cmd.idx[2] == 1'b0)
      addr_q[reg_cmd.idx[1:0]] <= reg_cmd.wdata;

  // exception outputs pulse one cycle after the cause; an execute hit
  // arrives while the instruction still sits before execution
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      status_q    <= bdu_pkg::RST_VAL;
      control_q   <= bdu_pkg::RST_VAL;
      reg_rdata_q <= bdu_pkg::RST_VAL;
      reg_fault_q <= 1'b0;
      dbg_exc_q   <= 1'b0;
      bkpt_exc_q  <= 1'b0;
    end
    else
    begin
      status_q    <= status_d;
      control_q   <= control_d;
      reg_rdata_q <= (reg_cmd.rd && acc_ok) ? rd_sel : reg_rdata_q;
      reg_fault_q <= reg_req && !priv_ok;
      dbg_exc_q   <= exc;
      bkpt_exc_q  <= sw_bkpt_exec;
    end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_step;
    instr_done && trap_step_flag;
  endsequence
  sequence s_step_seen;
    dbg_exc_q && status_q[bdu_pkg::ST_STEP_BIT];
  endsequence
  property p_step;
    s_step |=> s_step_seen;
  endproperty
  a_step: assert property (p_step) else $error("single step missed");

  property p_step_bit_only;
    !status_q[bdu_pkg::ST_STEP_BIT] && !step_hit && !wr_st |=> !status_q[bdu_pkg::ST_STEP_BIT];
  endproperty
  a_step_bit_only: assert property (p_step_bit_only) else $error("step bit set");

  property p_local_clear;
    task_switch |=> (control_q & bdu_pkg::CT_LOCALS) == bdu_pkg::RST_VAL;
  endproperty
  a_local_clear: assert property (p_local_clear) else $error("local enable kept");

  property p_global_keep;
    task_switch && !wr_ct |=>
      control_q[7:0] == ($past(control_q[7:0]) & ~bdu_pkg::CT_LOCALS[7:0]);
  endproperty
  a_global_keep: assert property (p_global_keep) else $error("global enable lost");

  property p_guard_clear;
    dbg_exc_q |-> !control_q[bdu_pkg::CT_GUARD_BIT];
  endproperty
  a_guard_clear: assert property (p_guard_clear) else $error("guard kept");

  property p_status_sticky;
    !wr_st && !exc |=> $stable(status_q);
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status changed");

  property p_priv;
    reg_req && !priv_ok |=> reg_fault_q && $stable(addr_q[0]) && $stable(control_q[31:14]);
  endproperty
  a_priv: assert property (p_priv) else $error("privilege not enforced");

  property p_exec_break;
    |(exec_m & armed) |=> dbg_exc_q;
  endproperty
  a_exec_break: assert property (p_exec_break) else $error("execute hit missed");

  // every matching slot, armed or not, must show its flag after any exception
  property p_hit_flag;
    exc |=> (status_q[3:0] & $past(hit_any)) == $past(hit_any);
  endproperty
  a_hit_flag: assert property (p_hit_flag) else $error("hit flag missing");

  property p_sw_bkpt;
    sw_bkpt_exec |=> bkpt_exc_q ##1 !bkpt_exc_q || $past(sw_bkpt_exec);
  endproperty
  a_sw_bkpt: assert property (p_sw_bkpt) else $error("software breakpoint lost");

endmodule // bdu_breakpoint_unit
`default_nettype wire

// ===== bdu_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// core fetch and access pipeline model
// ************************************************************
module bdu_core_model (
  // clock
  input  wire logic           clk,
  // pipeline to the debug unit
  output var bdu_pkg::bdu_access_t exec_acc,
  output var bdu_pkg::bdu_access_t data_acc,
  output logic                instr_done,
  output logic                trap_step_flag,
  output logic                task_switch,
  output logic                task_switch_trap_flag,
  output logic                sw_bkpt_exec
);
  // quiet pipeline at time zero
  initial
  begin
    exec_acc = '0;
    data_acc = '0;
    {instr_done, trap_step_flag, task_switch, task_switch_trap_flag, sw_bkpt_exec} = '0;
  end

  // one pipeline cycle; released fields show inverted junk, not the last value
  task automatic step(input logic [35:0] e, input logic [35:0] d, input logic [4:0] ev);
    @(posedge clk);
    exec_acc <= e;
    data_acc <= d;
    {instr_done, trap_step_flag, task_switch, task_switch_trap_flag, sw_bkpt_exec} <= ev;
    @(posedge clk);
    exec_acc <= {1'b0, ~e[34:0]};
    data_acc <= {1'b0, ~d[34:0]};
    {instr_done, trap_step_flag, task_switch, task_switch_trap_flag, sw_bkpt_exec} <=
      {3'h0, ~ev[1], 1'b0};
    #1;
  endtask
endmodule // bdu_core_model
`default_nettype wire

// ===== bdu_pkg.sv
`default_nettype none
package bdu_pkg;
  // ************************************************************
  // register indices of the register-move port
  // ************************************************************
  localparam logic [2:0] IDX_ADDR0   = 3'h0;
  localparam logic [2:0] IDX_ADDR1   = 3'h1;
  localparam logic [2:0] IDX_ADDR2   = 3'h2;
  localparam logic [2:0] IDX_ADDR3   = 3'h3;
  localparam logic [2:0] IDX_STATUS  = 3'h6;
  localparam logic [2:0] IDX_CONTROL = 3'h7;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int NUM_BP       = 4;
  localparam int ST_STEP_BIT  = 14;
  localparam int ST_TSW_BIT   = 15;
  localparam int CT_GUARD_BIT = 13;
  localparam int CT_FIELD_LSB = 16;
  localparam int CT_GRP_W     = 4;
  localparam logic [31:0] ST_WMASK  = 32'h0000_c00f;
  localparam logic [31:0] CT_WMASK  = 32'hffff_23ff;
  localparam logic [31:0] CT_LOCALS = 32'h0000_0055;
  localparam logic [31:0] RST_VAL   = 32'h0000_0000;

  // access-type, size and privilege-level encodings
  localparam logic [1:0] RW_EXEC  = 2'h0;
  localparam logic [1:0] RW_WRITE = 2'h1;
  localparam logic [1:0] RW_RDWR  = 2'h3;
  localparam logic [1:0] LEN_4    = 2'h3;
  localparam logic [1:0] PL_ZERO  = 2'h0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic        valid;
    logic        we;     // data write, ignored for fetches
    logic [1:0]  size;   // bytes minus one
    logic [31:0] addr;   // linear address
  } bdu_access_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  cpl;
    logic [2:0]  idx;
    logic [31:0] wdata;
  } bdu_regcmd_t;
endpackage
`default_nettype wire

// ===== test_breakpoint_debug_unit.sv
`timescale 1ns/1ns
`default_nettype none
module test_breakpoint_debug_unit;
  // ************************************************************
  // clock, reset and design
  // ************************************************************
  logic                 clk;
  logic                 sys_rst;
  bdu_pkg::bdu_regcmd_t reg_cmd;
  bdu_pkg::bdu_access_t exec_acc;
  bdu_pkg::bdu_access_t data_acc;
  logic                 instr_done, trap_step_flag, task_switch, task_switch_trap_flag;
  logic                 sw_bkpt_exec, reg_fault_q, dbg_exc_q, bkpt_exc_q;
  logic [31:0]          reg_rdata_q;
  int                   n_errors = 0;
  int                   checked = 0;
  localparam logic [2:0] ST = bdu_pkg::IDX_STATUS;
  localparam logic [2:0] CT = bdu_pkg::IDX_CONTROL;

  bdu_breakpoint_unit u_bdu_breakpoint_unit (.clk(clk), .sys_rst(sys_rst), .reg_cmd(reg_cmd),
    .reg_rdata_q(reg_rdata_q), .reg_fault_q(reg_fault_q), .exec_acc(exec_acc),
    .data_acc(data_acc), .instr_done(instr_done), .trap_step_flag(trap_step_flag),
    .task_switch(task_switch), .task_switch_trap_flag(task_switch_trap_flag),
    .sw_bkpt_exec(sw_bkpt_exec), .dbg_exc_q(dbg_exc_q), .bkpt_exc_q(bkpt_exc_q));
  bdu_core_model u_bdu_core_model (.clk(clk), .exec_acc(exec_acc), .data_acc(data_acc),
    .instr_done(instr_done), .trap_step_flag(trap_step_flag), .task_switch(task_switch),
    .task_switch_trap_flag(task_switch_trap_flag), .sw_bkpt_exec(sw_bkpt_exec));

  // 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // register move; released fields inverted so stale values never look valid
  task automatic rop(input logic w, input logic [1:0] c, input logic [2:0] i,
                     input logic [31:0] d);
    @(posedge clk);
    reg_cmd <= {~w, w, c, i, d};
    @(posedge clk);
    reg_cmd <= {2'h0, ~c, ~i, ~d};
    #1;
  endtask

  task automatic ev(input logic [35:0] e, input logic [35:0] d, input logic [4:0] v,
                    input logic x);
    u_bdu_core_model.step(e, d, v);
    chk(dbg_exc_q, x);
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // exec breakpoint, local enable, guard set beforehand
  task automatic t_exec;
    rop(1, 0, 3'h0, 32'h0000_1000);
    rop(1, 0, CT, 32'h0000_2001);
    ev(36'h0, 36'hc_0000_1000, 5'h00, 1'b0);
    ev(36'h8_0000_1000, 36'h0, 5'h00, 1'b1);
    rop(0, 0, ST, 32'h0);
    chk(reg_rdata_q, 32'h0000_0001);
    rop(0, 0, CT, 32'h0);
    chk(reg_rdata_q, 32'h0000_0001);
  endtask

  // write-only 4-byte watch plus a disabled read/write watch inside it
  task automatic t_data;
    rop(1, 0, 3'h1, 32'h0000_0200);
    rop(1, 0, 3'h2, 32'h0000_0201);
    rop(1, 0, CT, 32'h03d0_0009);
    ev(36'h0, 36'h8_0000_0201, 5'h00, 1'b0);
    ev(36'h0, 36'hc_0000_0204, 5'h00, 1'b0);
    ev(36'h0, 36'hf_0000_01fe, 5'h00, 1'b1);
    rop(0, 0, ST, 32'h0);
    chk(reg_rdata_q, 32'h0000_0007);
    rop(1, 0, ST, 32'h0);
    rop(0, 0, ST, 32'h0);
    chk(reg_rdata_q, 32'h0);
  endtask

  // task switch into trapping task, then single step and software breakpoint
  task automatic t_task;
    ev(36'h0, 36'h0, 5'h06, 1'b1);
    rop(0, 0, ST, 32'h0);
    chk(reg_rdata_q, 32'h0000_8000);
    rop(0, 0, CT, 32'h0);
    chk(reg_rdata_q, 32'h03d0_0008);
    rop(1, 0, ST, 32'h0);
    ev(36'h0, 36'h0, 5'h18, 1'b1);
    rop(0, 0, ST, 32'h0);
    chk(reg_rdata_q, 32'h0000_4000);
    u_bdu_core_model.step(36'h0, 36'h0, 5'h01);
    chk(bkpt_exc_q, 1'b1);
  endtask

  // privilege fault raises reg_fault_q; guard trip raises the debug exception and drops the guard
  task automatic t_prot;
    rop(1, 2'h1, CT, 32'h0);
    chk(reg_fault_q, 1'b1);
    rop(1, 0, CT, 32'h03d0_2008);
    rop(0, 0, ST, 32'h0);
    chk(dbg_exc_q, 1'b1);
    rop(0, 0, CT, 32'h0);
    chk(reg_rdata_q, 32'h03d0_0008);
  endtask

  // two-byte watch on an unaligned address, unused type on an armed slot, unused index
  task automatic t_size;
    rop(1, 0, ST, 32'h0);
    rop(1, 0, 3'h3, 32'h0000_0303);
    rop(1, 0, CT, 32'h7200_00a0);
    ev(36'h0, 36'h8_0000_0301, 5'h00, 1'b0);
    ev(36'h0, 36'h8_0000_0302, 5'h00, 1'b1);
    ev(36'h0, 36'hc_0000_0201, 5'h00, 1'b0);
    ev(36'h0, 36'h8_0000_0304, 5'h00, 1'b0);
    rop(0, 0, ST, 32'h0);
    chk(reg_rdata_q, 32'h0000_0008);
    chk(reg_fault_q, 1'b0);
    rop(0, 0, 3'h4, 32'h0);
    chk(reg_rdata_q, 32'h0);
  endtask

  // mid-run reset drops every enable, so a former hit address stays quiet
  task automatic t_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(dbg_exc_q, 1'b0);
    ev(36'h0, 36'h8_0000_0302, 5'h00, 1'b0);
    rop(0, 0, CT, 32'h0);
    chk(reg_rdata_q, 32'h0);
    rop(0, 0, 3'h3, 32'h0);
    chk(reg_rdata_q, 32'h0);
  endtask

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    reg_cmd = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_exec();
    t_data();
    t_task();
    t_prot();
    t_size();
    t_reset();
    finish_test();
  end

  // watchdog, well past the fewer than a hundred cycles the run needs
  initial
  begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule // test_breakpoint_debug_unit
`default_nettype wire
